//--- hdl/rsca_alu.sv
`timescale 1ns/1ps
module rsca_alu
    import rsca_pkg::*;
(
    rsca_alu_if.alu a
);

    logic [DATA_W:0] sub_ext;
    logic [DATA_W-1:0] lane_res;
    logic [3:0] lane_ge;

    // Subtraction as operand2 + NOT first + carry; the carry out is NOT borrow.
    always_comb begin
        sub_ext = {1'b0, a.operand2} + {1'b0, ~a.first_src}
                  + {{DATA_W{1'b0}}, a.carry_in};
    end

    genvar g;
    generate
        for (g = 0; g < DATA_W / LANE_W; g++) begin : g_lane
            logic [LANE_W:0] sum;
            always_comb begin
                sum = {a.first_src[g*LANE_W+LANE_W-1], a.first_src[g*LANE_W +: LANE_W]}
                    + {a.second_src[g*LANE_W+LANE_W-1],
                       a.second_src[g*LANE_W +: LANE_W]};
            end
            assign lane_res[g*LANE_W +: LANE_W] = sum[LANE_W-1:0];
            assign lane_ge[2*g +: 2] = {2{~sum[LANE_W]}};
        end
    endgenerate

    always_comb begin
        a.ge = lane_ge;
        if (a.op == RSCA_OP_DHADD) begin
            a.result = lane_res;
            a.nzcv = 4'h0;
        end else begin
            a.result = sub_ext[DATA_W-1:0];
            a.nzcv[3] = sub_ext[DATA_W-1];
            a.nzcv[2] = (sub_ext[DATA_W-1:0] == RST_WORD);
            a.nzcv[1] = sub_ext[DATA_W];
            a.nzcv[0] = (a.operand2[DATA_W-1] != a.first_src[DATA_W-1])
                      && (sub_ext[DATA_W-1] != a.operand2[DATA_W-1]);
        end
    end

endmodule : rsca_alu

//--- hdl/rsca_alu_if.sv
`timescale 1ns/1ps
interface rsca_alu_if;
    import rsca_pkg::*;
    rsca_op_t op;
    logic [DATA_W-1:0] operand2;
    logic [DATA_W-1:0] first_src;
    logic [DATA_W-1:0] second_src;
    logic carry_in;
    logic [DATA_W-1:0] result;
    logic [3:0] nzcv;
    logic [3:0] ge;

    modport user (output op, operand2, first_src, second_src, carry_in,
                  input result, nzcv, ge);
    modport alu (input op, operand2, first_src, second_src, carry_in,
                 output result, nzcv, ge);
endinterface : rsca_alu_if

//--- hdl/rsca_pkg.sv
// Functional notes
// - Reverse subtract with borrow: result = operand2 - first source - NOT carry.
// - Instruction bit 20 set writes the status word; clear leaves it alone.
// - With bit 20 clear neither reverse subtract touches the status word.
// - Flag update, destination not PC: N from result bit 31, Z when result zero.
// - Borrow-in form: carry = NOT borrow of three-term subtraction, overflow = signed overflow.
// - Plain reverse subtract: overflow is signed overflow of operand2 minus first source.
// - Flag update into PC copies saved status word; unpredictable in user/system modes.
// - Carry after subtraction means no borrow; borrow-in subtracts one extra when carry 0.
// - Higher-or-same equals carry set; lower equals carry clear in condition evaluation.
// - Immediate select is bit 25; shifter operand field is bits 11 to 0.
// - Register form with bits 7 and 4 set goes to extension decode, not here.
// - Execute only when the 4-bit predicate passes; always is the default predicate.
// - Dual halfword add: two independent signed 16-bit adds, updating lane flags.
// - Each destination half takes its lane sum low 16 bits, no inter-lane carry.
// - Lane flag pair becomes 11 when that lane's full sum is non-negative, else 00.
package rsca_pkg;

    localparam int DATA_W = 32;
    localparam int ADR_W = 8;
    localparam int LANE_W = 16;

    // Register byte offsets.
    localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADR_W-1:0] OFS_INSTR = 8'h04;
    localparam logic [ADR_W-1:0] OFS_OPERAND2 = 8'h08;
    localparam logic [ADR_W-1:0] OFS_FIRST_SRC = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_SECOND_SRC = 8'h10;
    localparam logic [ADR_W-1:0] OFS_STATUS_WORD = 8'h14;
    localparam logic [ADR_W-1:0] OFS_SAVED_WORD = 8'h18;
    localparam logic [ADR_W-1:0] OFS_RESULT = 8'h1C;
    localparam logic [ADR_W-1:0] OFS_EXEC_STAT = 8'h20;

    localparam int CTRL_GO_BIT = 0;

    // Execution status fields.
    localparam int ES_BUSY = 0;
    localparam int ES_PASSED = 1;
    localparam int ES_EXT = 2;
    localparam int ES_DEST = 3;
    localparam int ES_SW = 4;
    localparam int ES_UNPRED = 5;
    localparam int ES_OP_LO = 8;

    // Status word layout.
    localparam int SW_N = 31;
    localparam int SW_Z = 30;
    localparam int SW_C = 29;
    localparam int SW_V = 28;
    localparam int SW_LANE_LO = 16;
    localparam int MODE_W = 5;
    localparam logic [MODE_W-1:0] MODE_USER = 5'h10;
    localparam logic [MODE_W-1:0] MODE_SYSTEM = 5'h1F;

    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_STATUS_WORD = 32'h0000_0013;

    // Instruction fields.
    localparam int IN_COND_LO = 28;
    localparam int IN_IMM = 25;
    localparam int IN_FLAG_UPD = 20;
    localparam int IN_RD_LO = 12;
    localparam int IN_B7 = 7;
    localparam int IN_B4 = 4;
    localparam int IN_SHOP_HI = 11;
    localparam logic [1:0] DP_CLASS = 2'h0;
    localparam logic [3:0] OPC_RVS = 4'h3;
    localparam logic [3:0] OPC_RVC = 4'h7;
    localparam logic [7:0] DHADD_HI = 8'h61;
    localparam logic [3:0] DHADD_LO = 4'h1;
    localparam logic [3:0] PC_IDX = 4'hF;

    // Predicate codes.
    localparam logic [3:0] COND_EQ = 4'h0;
    localparam logic [3:0] COND_NE = 4'h1;
    localparam logic [3:0] COND_CSET = 4'h2;
    localparam logic [3:0] COND_CCLR = 4'h3;
    localparam logic [3:0] COND_MI = 4'h4;
    localparam logic [3:0] COND_PL = 4'h5;
    localparam logic [3:0] COND_VS = 4'h6;
    localparam logic [3:0] COND_VC = 4'h7;
    localparam logic [3:0] COND_HI = 4'h8;
    localparam logic [3:0] COND_LS = 4'h9;
    localparam logic [3:0] COND_SGE = 4'hA;
    localparam logic [3:0] COND_LT = 4'hB;
    localparam logic [3:0] COND_GT = 4'hC;
    localparam logic [3:0] COND_LE = 4'hD;
    localparam logic [3:0] COND_ALWAYS = 4'hE;

    typedef enum logic [1:0] {
        RSCA_OP_NONE,
        RSCA_OP_RVS,
        RSCA_OP_RVC,
        RSCA_OP_DHADD
    } rsca_op_t;

endpackage : rsca_pkg

//--- hdl/rsca_top.sv
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module rsca_top
    import rsca_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic rd_we_o,
    output logic [3:0] rd_idx_o,
    output logic [DATA_W-1:0] rd_data_o,
    output logic [DATA_W-1:0] status_word_o,
    output logic ext_route_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic ack;
        logic [DATA_W-1:0] dat;
        logic busy;
        logic [DATA_W-1:0] instr;
        logic [DATA_W-1:0] operand2;
        logic [DATA_W-1:0] first_src;
        logic [DATA_W-1:0] second_src;
        logic [DATA_W-1:0] status_word;
        logic [DATA_W-1:0] saved_word;
        logic [DATA_W-1:0] result;
        logic passed;
        logic ext;
        logic dest;
        logic sw_wr;
        logic unpred;
        rsca_op_t last_op;
        logic rd_we;
        logic [3:0] rd_idx;
    } rsca_state_t;

    rsca_state_t st_r;
    rsca_state_t st_nxt;

    rsca_alu_if alu_bus ();

    rsca_alu u_alu (
        .a(alu_bus)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Byte-lane merge for Wishbone writes.
    function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_v,
                                                     input logic [DATA_W-1:0] new_v,
                                                     input logic [3:0] sel);
        logic [DATA_W-1:0] m;
        m = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                m[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return m;
    endfunction : lane_merge

    // Predicate evaluation against the current flags.
    function automatic logic cond_pass(input logic [3:0] c, input logic [DATA_W-1:0] sw);
        logic n;
        logic z;
        logic cf;
        logic v;
        logic p;
        n = sw[SW_N];
        z = sw[SW_Z];
        cf = sw[SW_C];
        v = sw[SW_V];
        unique case (c)
            COND_EQ: p = z;
            COND_NE: p = !z;
            COND_CSET: p = cf;
            COND_CCLR: p = !cf;
            COND_MI: p = n;
            COND_PL: p = !n;
            COND_VS: p = v;
            COND_VC: p = !v;
            COND_HI: p = cf && !z;
            COND_LS: p = !cf || z;
            COND_SGE: p = (n == v);
            COND_LT: p = (n != v);
            COND_GT: p = !z && (n == v);
            COND_LE: p = z || (n != v);
            COND_ALWAYS: p = 1'b1;
            // The remaining code is another instruction space, never a pass here.
            default: p = 1'b0;
        endcase
        return p;
    endfunction : cond_pass

    // Classifies the instruction word.
    function automatic rsca_op_t decode_op(input logic [DATA_W-1:0] ins);
        rsca_op_t o;
        o = RSCA_OP_NONE;
        if (ins[27:26] == DP_CLASS && ins[24:21] == OPC_RVS) begin
            o = RSCA_OP_RVS;
        end else if (ins[27:26] == DP_CLASS && ins[24:21] == OPC_RVC) begin
            o = RSCA_OP_RVC;
        end else if (ins[27:20] == DHADD_HI && ins[7:4] == DHADD_LO) begin
            o = RSCA_OP_DHADD;
        end
        return o;
    endfunction : decode_op

    ////////////////////////////////////////////////////////////////////////////////
    // Decode of the held instruction.

    rsca_op_t op_dec;
    logic is_sub;
    logic ext_space;
    logic pass;
    logic flag_upd;
    logic [3:0] rd_field;
    logic has_saved;

    always_comb begin
        op_dec = decode_op(st_r.instr);
        is_sub = (op_dec == RSCA_OP_RVS) || (op_dec == RSCA_OP_RVC);
        // Register form with bits 7 and 4 set belongs to the extension space.
        ext_space = is_sub && !st_r.instr[IN_IMM]
                    && st_r.instr[IN_B7] && st_r.instr[IN_B4];
        pass = cond_pass(st_r.instr[IN_COND_LO +: 4], st_r.status_word);
        flag_upd = st_r.instr[IN_FLAG_UPD];
        rd_field = st_r.instr[IN_RD_LO +: 4];
        has_saved = (st_r.status_word[MODE_W-1:0] != MODE_USER)
                    && (st_r.status_word[MODE_W-1:0] != MODE_SYSTEM);
    end

    // The shifter operand value arrives already formed; only its bits steer decode.
    always_comb begin
        alu_bus.op = op_dec;
        alu_bus.operand2 = st_r.operand2;
        alu_bus.first_src = st_r.first_src;
        alu_bus.second_src = st_r.second_src;
        // Plain reverse subtract has no borrow in; the borrow form uses the carry.
        alu_bus.carry_in = (op_dec == RSCA_OP_RVC) ? st_r.status_word[SW_C] : 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    logic wb_req;
    logic wb_wr;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] exec_stat;

    always_comb begin
        st_nxt = st_r;
        wb_req = wb_cyc_i && wb_stb_i;
        // The write lands on the edge where the master sees ack high.
        wb_wr = wb_req && wb_we_i && st_r.ack;

        exec_stat = RST_WORD;
        exec_stat[ES_BUSY] = st_r.busy;
        exec_stat[ES_PASSED] = st_r.passed;
        exec_stat[ES_EXT] = st_r.ext;
        exec_stat[ES_DEST] = st_r.dest;
        exec_stat[ES_SW] = st_r.sw_wr;
        exec_stat[ES_UNPRED] = st_r.unpred;
        exec_stat[ES_OP_LO +: 2] = st_r.last_op;

        unique case (wb_adr_i)
            OFS_INSTR: rd_mux = st_r.instr;
            OFS_OPERAND2: rd_mux = st_r.operand2;
            OFS_FIRST_SRC: rd_mux = st_r.first_src;
            OFS_SECOND_SRC: rd_mux = st_r.second_src;
            OFS_STATUS_WORD: rd_mux = st_r.status_word;
            OFS_SAVED_WORD: rd_mux = st_r.saved_word;
            OFS_RESULT: rd_mux = st_r.result;
            OFS_EXEC_STAT: rd_mux = exec_stat;
            // Control is write-only and unmapped offsets read as zero.
            default: rd_mux = RST_WORD;
        endcase

        // Single-wait-state slave: ack one cycle after the request, then drops.
        st_nxt.ack = wb_req && !st_r.ack;
        st_nxt.dat = rd_mux;
        st_nxt.rd_we = 1'b0;

        ////////////////////////////////////////////////////////////////////////////
        // Execution, one cycle after the go write.
        if (st_r.busy) begin
            st_nxt.busy = 1'b0;
            st_nxt.last_op = op_dec;
            st_nxt.passed = pass;
            st_nxt.ext = ext_space;
            st_nxt.dest = 1'b0;
            st_nxt.sw_wr = 1'b0;
            st_nxt.unpred = 1'b0;
            st_nxt.rd_idx = rd_field;
            if (op_dec != RSCA_OP_NONE && !ext_space && pass) begin
                st_nxt.result = alu_bus.result;
                st_nxt.rd_we = 1'b1;
                st_nxt.dest = 1'b1;
                if (op_dec == RSCA_OP_DHADD) begin
                    st_nxt.status_word[SW_LANE_LO +: 4] = alu_bus.ge;
                    st_nxt.sw_wr = 1'b1;
                end else if (flag_upd) begin
                    if (rd_field == PC_IDX) begin
                        // Without a saved copy the status word is left as it was.
                        if (has_saved) begin
                            st_nxt.status_word = st_r.saved_word;
                            st_nxt.sw_wr = 1'b1;
                        end else begin
                            st_nxt.unpred = 1'b1;
                        end
                    end else begin
                        st_nxt.status_word[SW_N] = alu_bus.nzcv[3];
                        st_nxt.status_word[SW_Z] = alu_bus.nzcv[2];
                        st_nxt.status_word[SW_C] = alu_bus.nzcv[1];
                        st_nxt.status_word[SW_V] = alu_bus.nzcv[0];
                        st_nxt.sw_wr = 1'b1;
                    end
                end
            end
        end

        ////////////////////////////////////////////////////////////////////////////
        // Register writes; an execution in flight owns the status word.
        if (wb_wr) begin
            unique case (wb_adr_i)
                OFS_CTRL: begin
                    if (wb_sel_i[0] && wb_dat_i[CTRL_GO_BIT]) begin
                        st_nxt.busy = 1'b1;
                    end
                end
                OFS_INSTR: st_nxt.instr = lane_merge(st_r.instr, wb_dat_i, wb_sel_i);
                OFS_OPERAND2: begin
                    st_nxt.operand2 = lane_merge(st_r.operand2, wb_dat_i, wb_sel_i);
                end
                OFS_FIRST_SRC: begin
                    st_nxt.first_src = lane_merge(st_r.first_src, wb_dat_i, wb_sel_i);
                end
                OFS_SECOND_SRC: begin
                    st_nxt.second_src = lane_merge(st_r.second_src, wb_dat_i, wb_sel_i);
                end
                OFS_STATUS_WORD: begin
                    if (!st_r.busy) begin
                        st_nxt.status_word = lane_merge(st_r.status_word, wb_dat_i,
                                                        wb_sel_i);
                    end
                end
                OFS_SAVED_WORD: begin
                    st_nxt.saved_word = lane_merge(st_r.saved_word, wb_dat_i, wb_sel_i);
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '{ack: 1'b0, dat: RST_WORD, busy: 1'b0, instr: RST_WORD,
                      operand2: RST_WORD, first_src: RST_WORD, second_src: RST_WORD,
                      status_word: RST_STATUS_WORD, saved_word: RST_WORD,
                      result: RST_WORD, passed: 1'b0, ext: 1'b0, dest: 1'b0,
                      sw_wr: 1'b0, unpred: 1'b0, last_op: RSCA_OP_NONE,
                      rd_we: 1'b0, rd_idx: 4'h0};
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.dat;
    assign rd_we_o = st_r.rd_we;
    assign rd_idx_o = st_r.rd_idx;
    assign rd_data_o = st_r.result;
    assign status_word_o = st_r.status_word;
    assign ext_route_o = st_r.ext;

endmodule : rsca_top

//--- verification/rsca_rf_model.sv
`timescale 1ns/1ps
module rsca_rf_model
    import rsca_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [3:0] idx_i,
    input wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0] last_o,
    output logic [3:0] last_idx_o,
    output int wr_cnt_o
);
    // The register file only records write-backs, so a missing or extra pulse shows in the count.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_cnt_o <= 0;
        end else if (we_i) begin
            last_o <= data_i;
            last_idx_o <= idx_i;
            wr_cnt_o <= wr_cnt_o + 1;
        end
    end
endmodule : rsca_rf_model

//--- verification/rsca_top_sva.sv
`timescale 1ns/1ps
module rsca_top_sva
    import rsca_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic rd_we_o,
    input wire logic [DATA_W-1:0] rd_data_o,
    input wire logic [DATA_W-1:0] status_word_o,
    input wire logic ext_route_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [DATA_W-1:0] ins_r;
    logic [DATA_W-1:0] sav_r;
    logic req, wr, go, rs, ext, fire;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    assign wr = wb_ack_o && wb_we_i && ce_i;
    assign go = wr && wb_adr_i == OFS_CTRL && wb_dat_i[CTRL_GO_BIT];
    assign rs = ins_r[27:26] == DP_CLASS && (ins_r[24:21] == OPC_RVS || ins_r[24:21] == OPC_RVC);
    assign ext = rs && !ins_r[IN_IMM] && ins_r[IN_B7] && ins_r[IN_B4];
    assign fire = go && rs && !ext && ins_r[31:28] == COND_ALWAYS;
    // Shadows of what software wrote, so the checker can predict the next commit.
    always_ff @(posedge clk_i) begin
        if (wr && wb_adr_i == OFS_INSTR) begin
            ins_r <= wb_dat_i;
        end
        if (wr && wb_adr_i == OFS_SAVED_WORD) begin
            sav_r <= wb_dat_i;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_commit;
        ##2 rd_we_o ##1 !rd_we_o;
    endsequence
    sequence s_held;
        ##2 status_word_o == $past(status_word_o, 2);
    endsequence
    property p_ack; req |=> s_ack; endproperty
    property p_commit; fire |-> s_commit; endproperty
    property p_cause; rd_we_o |-> $past(go, 2); endproperty
    property p_sw_src;
        $changed(status_word_o) |-> $past(wr && wb_adr_i == OFS_STATUS_WORD) || $past(go, 2);
    endproperty
    property p_ext; go && ext |-> ##2 ext_route_o && !rd_we_o; endproperty
    property p_pred; go && ins_r[31:28] == 4'hF |-> s_held and ##2 !rd_we_o; endproperty
    property p_keep; fire && !ins_r[IN_FLAG_UPD] |-> s_held; endproperty
    property p_nz;
        fire && ins_r[IN_FLAG_UPD] && ins_r[15:12] != PC_IDX |-> ##2
            status_word_o[SW_N] == rd_data_o[31] && status_word_o[SW_Z] == (rd_data_o == '0);
    endproperty
    property p_restore;
        fire && ins_r[IN_FLAG_UPD] && ins_r[15:12] == PC_IDX && status_word_o[4:0] != MODE_USER
            && status_word_o[4:0] != MODE_SYSTEM |-> ##2 status_word_o == sav_r;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
    a_commit: assert property (p_commit) else $error("no write-back pulse");
    a_cause: assert property (p_cause) else $error("write-back without start");
    a_sw_src: assert property (p_sw_src) else $error("status changed on its own");
    a_ext: assert property (p_ext) else $error("extension word executed");
    a_pred: assert property (p_pred) else $error("never predicate executed");
    a_keep: assert property (p_keep) else $error("status changed without update");
    a_nz: assert property (p_nz) else $error("N or Z flag wrong");
    a_restore: assert property (p_restore) else $error("saved word not restored");
endmodule : rsca_top_sva

bind rsca_top rsca_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .rd_we_o(rd_we_o), .rd_data_o(rd_data_o),
    .status_word_o(status_word_o), .ext_route_o(ext_route_o));

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import rsca_pkg::*;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic ce_i = 1'h1;
    logic wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0;
    logic [ADR_W-1:0] wb_adr = '0;
    logic [3:0] wb_sel = 4'h0;
    logic [DATA_W-1:0] wb_dat = '0;
    logic [DATA_W-1:0] wb_rdat, rd_data, sw_o, m_last;
    logic wb_ack, rd_we, ext_o;
    logic [3:0] rd_idx, m_idx;
    int m_cnt;
    int error_cnt = 0;
    int n_tests = 0;
    always #4 clk_i = ~clk_i;
    rsca_top i_rsca_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .rd_we_o(rd_we),
        .rd_idx_o(rd_idx), .rd_data_o(rd_data), .status_word_o(sw_o), .ext_route_o(ext_o));
    rsca_rf_model i_rsca_rf_model (.clk_i(clk_i), .rst_i(rst_i), .we_i(rd_we), .idx_i(rd_idx),
        .data_i(rd_data), .last_o(m_last), .last_idx_o(m_idx), .wr_cnt_o(m_cnt));
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // The request is held until ack is sampled; one idle edge follows so the strobe really drops.
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= w;
        wb_adr <= a;
        wb_sel <= 4'hF;
        wb_dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'h1 && n < 20);
        chk("wb_ack", 32'h1, 32'(wb_ack));
        q = wb_rdat;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        wb_we <= 1'h0;
        @(posedge clk_i);
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'h1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        acc(1'h0, a, 32'h0, q);
    endtask : rd
    // Operand a feeds both the shifted operand and the second source; the dual add commutes.
    task automatic t(input logic [31:0] ins, a, b, sw, sv, er, esw, input logic w,
                     output logic [31:0] es);
        int c0;
        logic [31:0] q;
        c0 = m_cnt;
        wr(OFS_INSTR, ins);
        wr(OFS_OPERAND2, a);
        wr(OFS_SECOND_SRC, a);
        wr(OFS_FIRST_SRC, b);
        wr(OFS_STATUS_WORD, sw);
        wr(OFS_SAVED_WORD, sv);
        wr(OFS_CTRL, 32'h0000_0001);
        for (int n = 0; n < 8; n++) begin
            rd(OFS_EXEC_STAT, es);
            if (es[ES_BUSY] === 1'h0) break;
        end
        chk("busy", 32'h0, 32'(es[ES_BUSY]));
        chk("wr_cnt", 32'(c0 + w), 32'(m_cnt));
        chk("status", esw, sw_o);
        if (w) begin
            rd(OFS_RESULT, q);
            chk("result", er, q);
            chk("rf_data", er, m_last);
            chk("rd_idx", 32'(ins[15:12]), 32'(m_idx));
        end
    endtask : t
    function automatic logic [35:0] rsx(input logic [31:0] a, b, input logic c);
        logic [32:0] d;
        d = {1'h0, a} - {1'h0, b} - {32'h0, !c};
        return {d[31], d[31:0] == 32'h0, !d[32], a[31] != b[31] && d[31] != a[31], d[31:0]};
    endfunction : rsx
    function automatic logic [35:0] sadd(input logic [31:0] a, b);
        logic [16:0] l, h;
        l = {a[15], a[15:0]} + {b[15], b[15:0]};
        h = {a[31], a[31:16]} + {b[31], b[31:16]};
        return {{2{!h[16]}}, {2{!l[16]}}, h[15:0], l[15:0]};
    endfunction : sadd
    function automatic logic [31:0] dp(input logic [3:0] cd, op, input logic s,
                                       input logic [3:0] rdi, input logic i, input logic [11:0] sh);
        return {cd, 2'h0, i, op, s, 4'h1, rdi, sh};
    endfunction : dp
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(8 * 20000);
        error_cnt++;
        wrap_up();
    end
    initial begin
        logic [31:0] ta[6] = '{32'h0, 32'h5, 32'h8000_0000, 32'h5, 32'h7FFF_FFFF, 32'h5};
        logic [31:0] tb[6] = '{32'h1, 32'h5, 32'h1, 32'h5, 32'hFFFF_FFFF, 32'h5};
        logic [15:0] pm = 16'h55A6;
        logic [5:0] tc = 6'h1D;
        logic [35:0] e;
        logic [31:0] es, q, ins;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        chk("sw_rst", RST_STATUS_WORD, sw_o);
        ce_i <= 1'h0;
        fork
            wr(OFS_STATUS_WORD, 32'h0000_0011);
            begin
                repeat (4) @(posedge clk_i);
                chk("ce_hold", RST_STATUS_WORD, sw_o);
                ce_i <= 1'h1;
            end
        join
        chk("ce_wr", 32'h0000_0011, sw_o);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, q);
        chk("unmapped", 32'h0, q);
        for (int k = 0; k < 6; k++) begin
            e = rsx(ta[k], tb[k], k < 3 || tc[k]);
            ins = dp(COND_ALWAYS, k < 3 ? OPC_RVS : OPC_RVC, 1'h1, 4'h2, 1'h1, 12'h0);
            t(ins, ta[k], tb[k], {2'h0, tc[k], 29'h13}, 32'h0, e[31:0], {e[35:32], 28'h13}, 1'h1,
              es);
        end
        ins = dp(COND_ALWAYS, OPC_RVC, 1'h0, 4'h2, 1'h1, 12'h0);
        t(ins, 32'h5, 32'h5, 32'hF000_0013, 32'h0, 32'h0, 32'hF000_0013, 1'h1, es);
        ins = dp(COND_ALWAYS, OPC_RVS, 1'h1, PC_IDX, 1'h1, 12'h0);
        t(ins, 32'h9, 32'h1, 32'h13, 32'hA00F_0011, 32'h8, 32'hA00F_0011, 1'h1, es);
        t(ins, 32'h9, 32'h1, 32'h10, 32'hA00F_0011, 32'h8, 32'h10, 1'h1, es);
        chk("unpred", 32'h1, 32'(es[ES_UNPRED]));
        ins = dp(COND_ALWAYS, OPC_RVC, 1'h1, 4'h3, 1'h0, 12'h090);
        t(ins, 32'h5, 32'h5, 32'h13, 32'h0, 32'h0, 32'h13, 1'h0, es);
        chk("ext_route", 32'h1, 32'(ext_o));
        chk("ext_stat", 32'h1, 32'(es[ES_EXT]));
        ins = dp(COND_ALWAYS, OPC_RVC, 1'h1, 4'h3, 1'h1, 12'h090);
        t(ins, 32'h5, 32'h5, 32'h2000_0013, 32'h0, 32'h0, 32'h6000_0013, 1'h1, es);
        // With carry set, higher-or-same must pass and lower must fail.
        for (int k = 0; k < 16; k++) begin
            ins = dp(4'(k), OPC_RVS, 1'h1, 4'h4, 1'h1, 12'h0);
            t(ins, 32'h5, 32'h5, 32'h2000_0013, 32'h0, 32'h0, pm[k] ? 32'h6000_0013
              : 32'h2000_0013, pm[k], es);
        end
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        chk("sw_rst2", RST_STATUS_WORD, sw_o);
        for (int k = 0; k < 3; k++) begin
            e = k == 0 ? sadd(32'h0001_0001, 32'h7FFF_FFFF) : sadd(32'h8000_8000, 32'h8000_8000);
            ins = {k < 2 ? COND_ALWAYS : 4'hF, DHADD_HI, 4'h1, 4'h5, 4'h0, DHADD_LO, 4'h2};
            q = k == 0 ? 32'h0001_0001 : 32'h8000_8000;
            t(ins, q, k == 0 ? 32'h7FFF_FFFF : q, 32'hF005_0013, 32'h0, e[31:0],
              k < 2 ? {12'hF00, e[35:32], 16'h0013} : 32'hF005_0013, k < 2,
              es);
        end
        wrap_up();
    end
endmodule : tb_top
